// >>> inc/ration_if.sv
/*
  control and status lines between the register bank and one port's ration engine.
  assumes both ends run on ref_clk_i.
*/
`timescale 1ns/100ps
interface ration_if;
  logic              enable;
  logic              clear;
  logic [1:0]        response;
  logic [15:0]       threshold;
  logic              tick;
  logic [15:0]       charge_inc;
  logic              status;
  logic              disconnect;
  logic              sleep_req;
  logic              report;
  modport bank (output enable, clear, response, threshold, tick,
                output charge_inc, input status, disconnect,
                input sleep_req, report);
  modport engine (input enable, clear, response, threshold, tick,
                  input charge_inc, output status, disconnect,
                  output sleep_req, report);
endinterface

// >>> inc/ration_pkg.sv
/*
  shared constants for the charge ration and limit configuration bank.
  assumes a byte-wide register port driven by an smbus slave front end.
*/
package ration_pkg;
  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_THR2_HI   = 8'h20;
  localparam logic [7:0] ADDR_THR2_LO   = 8'h21;
  localparam logic [7:0] ADDR_RATION    = 8'h22;
  localparam logic [7:0] ADDR_LIM1      = 8'h23;
  localparam logic [7:0] ADDR_LIM2      = 8'h24;
  localparam logic [7:0] ADDR_PRODUCT   = 8'hfd;
  localparam logic [7:0] ADDR_MAKER     = 8'hfe;
  localparam logic [7:0] ADDR_REVISION  = 8'hff;
  // ---------------------------------------------------------------
  // reset values; identity values are arbitrary
  // ---------------------------------------------------------------
  localparam logic [7:0]  RATION_RST    = 8'h11;
  localparam logic [7:0]  LIM_RST       = 8'h96;
  localparam logic [15:0] THR_RST       = 16'hffff;
  localparam logic [7:0]  PRODUCT_VAL   = 8'h3c;
  localparam logic [7:0]  MAKER_VAL     = 8'ha7;
  localparam logic [7:0]  REVISION_VAL  = 8'h02;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int P2_EN_BIT   = 7;
  localparam int P2_CLR_BIT  = 6;
  localparam int P2_RSP_LSB  = 4;
  localparam int P1_EN_BIT   = 3;
  localparam int P1_CLR_BIT  = 2;
  localparam int P1_RSP_LSB  = 0;
  localparam int VSEL_LSB    = 6;
  localparam int DSCH_BIT    = 5;
  localparam int ISEL_LSB    = 2;
  // ---------------------------------------------------------------
  // timing: one accumulation update per second
  // ---------------------------------------------------------------
  localparam int  CLK_HZ        = 125000000;
  localparam int  UPDATE_S      = 1;
  localparam int  UPDATE_CYCLES = CLK_HZ * UPDATE_S;
  localparam int  ACC_W         = 26;
  localparam int  THR_W         = 16;
  localparam int  THR_SHIFT     = ACC_W - THR_W;
  typedef enum logic [1:0] {
    RSP_REPORT,
    RSP_REPORT_DISC,
    RSP_DISC_SLEEP,
    RSP_IGNORE
  } response_t;
endpackage

// >>> rtl/ration_engine.sv
/*
  one port's charge accumulator, threshold compare and response.
  assumes tick is a one-cycle pulse once per second from the bank.
*/
`timescale 1ns/100ps
module ration_engine (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  ration_if.engine  rif
);
  import ration_pkg::*;

  logic [ACC_W-1:0] acc_ff;
  logic             status_ff;
  logic [ACC_W-1:0] nxt_acc;
  logic             hit;

  // ---------------------------------------------------------------
  // accumulator
  // ---------------------------------------------------------------
  always_comb begin
    nxt_acc = acc_ff + ACC_W'(rif.charge_inc);
    if (nxt_acc < acc_ff) begin
      nxt_acc = '1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_ff <= '0;
    end else if (!rif.enable || rif.clear) begin
      acc_ff <= '0;
    end else if (rif.tick) begin
      acc_ff <= nxt_acc;
    end
  end

  // threshold lsb is 1024 accumulator lsbs (3.76 vs 0.00367 mAh)
  assign hit = {rif.threshold, THR_SHIFT'(0)} <= nxt_acc;

  // ---------------------------------------------------------------
  // status and response
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_ff <= 1'b0;
    end else if (!rif.enable || rif.clear) begin
      status_ff <= 1'b0;
    end else if (rif.tick && hit) begin
      status_ff <= 1'b1;
    end
  end

  always_comb begin
    rif.status     = status_ff;
    rif.report     = 1'b0;
    rif.disconnect = 1'b0;
    rif.sleep_req  = 1'b0;
    unique case (response_t'(rif.response))
      RSP_REPORT:      rif.report = status_ff;
      RSP_REPORT_DISC: begin
        rif.report     = status_ff;
        rif.disconnect = status_ff;
      end
      RSP_DISC_SLEEP:  begin
        rif.disconnect = status_ff;
        rif.sleep_req  = status_ff;
      end
      RSP_IGNORE:      rif.report = 1'b0;
    endcase
  end

  stat_clear_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    !rif.enable || rif.clear |=> !status_ff)
    else $error("ration status not cleared");
  acc_clear_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    !rif.enable |=> acc_ff == '0)
    else $error("accumulator not cleared");
  ignore_rsp_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    rif.response == 2'b11 |-> !rif.report && !rif.disconnect)
    else $error("ignore response acted");
  hit_cv: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(status_ff));
endmodule

// >>> rtl/ration_limit_regs.sv
/*
  ration configuration, port 2 threshold, current-limit behaviour and
  identification registers on a byte-wide register port.
  assumes the smbus slave gives one-cycle wr/rd strobes on ref_clk_i,
  and that charge increments come from the monitor on the same clock.
*/
// Function
// - disabled ration clears and halts accumulation
// - disable undoes response and clears status
// - clear bit zeroes count, clears status, alert
// - response field: report, disconnect, sleep, ignore
// - ration byte field positions per port
// - port 2 threshold sixteen bits, 3.76mAh steps
// - limit registers return to defaults after sleep
// - bits 7-6 select minimum bus voltage
// - host times discharge load, no device timer
// - auto discharge enable overrides host load bit
// - load parallels port while switch enabled
// - bits 4-2 select minimum bus current
// - three read-only identification registers FD-FF
// - accumulate once per second, then compare
// - threshold met sets status and applies response
`timescale 1ns/100ps
module ration_limit_regs (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [15:0] port1_threshold_i,
  input  wire logic [15:0] port1_charge_inc_i,
  input  wire logic [15:0] port2_charge_inc_i,
  input  wire logic        active_i,
  input  wire logic        sleep_exit_i,
  input  wire logic        auto_discharge_enable_i,
  input  wire logic        port1_switch_enable_i,
  input  wire logic        port2_switch_enable_i,
  output logic             port1_ration_status_o,
  output logic             port2_ration_status_o,
  output logic             port1_ration_alert_o,
  output logic             port2_ration_alert_o,
  output logic             port1_switch_block_o,
  output logic             port2_switch_block_o,
  output logic             sleep_request_o,
  output logic             port1_discharge_load_o,
  output logic             port2_discharge_load_o,
  output logic             port1_load_parallel_o,
  output logic             port2_load_parallel_o,
  output logic      [1:0]  port1_min_bus_voltage_sel_o,
  output logic      [1:0]  port2_min_bus_voltage_sel_o,
  output logic      [2:0]  port1_min_current_sel_o,
  output logic      [2:0]  port2_min_current_sel_o
);
  import ration_pkg::*;

  logic [7:0]  ration_config_ff;
  logic [7:0]  lim1_ff;
  logic [7:0]  lim2_ff;
  logic [15:0] port2_threshold_value_ff;
  logic [26:0] tick_cnt_ff;
  logic        tick_ff;
  logic [7:0]  nxt_rdata;
  logic [1:0]  sw_meta_ff;
  logic [1:0]  sw_sync_ff;

  ration_if p1 ();
  ration_if p2 ();

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = reg_wr_i && (reg_addr_i == a);
  endfunction

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ration_config_ff <= RATION_RST;
    end else if (wr_hit(ADDR_RATION)) begin
      ration_config_ff <= reg_wdata_i;
    end
  end

  // clear bits stay set until the host writes zero; engine holds idle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port2_threshold_value_ff <= THR_RST;
    end else if (wr_hit(ADDR_THR2_HI)) begin
      port2_threshold_value_ff[15:8] <= reg_wdata_i;
    end else if (wr_hit(ADDR_THR2_LO)) begin
      port2_threshold_value_ff[7:0] <= reg_wdata_i;
    end
  end

  // limit registers are not retained through sleep
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lim1_ff <= LIM_RST;
      lim2_ff <= LIM_RST;
    end else if (sleep_exit_i) begin
      lim1_ff <= LIM_RST;
      lim2_ff <= LIM_RST;
    end else begin
      // reserved bits stored as written; host keeps them
      if (wr_hit(ADDR_LIM1)) begin
        lim1_ff <= reg_wdata_i;
      end
      if (wr_hit(ADDR_LIM2)) begin
        lim2_ff <= reg_wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // one-second tick while active
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else if (!active_i) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 27'(UPDATE_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 27'd1;
      tick_ff     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // switch enable pins; two flops, so a pin edge lands 2 cycles late
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_meta_ff <= 2'b00;
      sw_sync_ff <= 2'b00;
    end else begin
      sw_meta_ff <= {port2_switch_enable_i, port1_switch_enable_i};
      sw_sync_ff <= sw_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // engines
  // ---------------------------------------------------------------
  assign p1.enable     = ration_config_ff[P1_EN_BIT];
  assign p1.clear      = ration_config_ff[P1_CLR_BIT];
  assign p1.response   = ration_config_ff[P1_RSP_LSB +: 2];
  assign p1.threshold  = port1_threshold_i;
  assign p1.tick       = tick_ff;
  assign p1.charge_inc = port1_charge_inc_i;
  assign p2.enable     = ration_config_ff[P2_EN_BIT];
  assign p2.clear      = ration_config_ff[P2_CLR_BIT];
  assign p2.response   = ration_config_ff[P2_RSP_LSB +: 2];
  assign p2.threshold  = port2_threshold_value_ff;
  assign p2.tick       = tick_ff;
  assign p2.charge_inc = port2_charge_inc_i;

  ration_engine u_eng1 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .rif       (p1.engine)
  );
  ration_engine u_eng2 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .rif       (p2.engine)
  );

  assign port1_ration_status_o = p1.status;
  assign port2_ration_status_o = p2.status;
  // alert released on clear unless other sources hold it outside
  assign port1_ration_alert_o  = p1.report;
  assign port2_ration_alert_o  = p2.report;
  assign port1_switch_block_o  = p1.disconnect;
  assign port2_switch_block_o  = p2.disconnect;
  assign sleep_request_o       = p1.sleep_req | p2.sleep_req;

  // ---------------------------------------------------------------
  // limit behaviour fields
  // ---------------------------------------------------------------
  assign port1_min_bus_voltage_sel_o = lim1_ff[VSEL_LSB +: 2];
  assign port2_min_bus_voltage_sel_o = lim2_ff[VSEL_LSB +: 2];
  assign port1_min_current_sel_o     = lim1_ff[ISEL_LSB +: 3];
  assign port2_min_current_sel_o     = lim2_ff[ISEL_LSB +: 3];
  // no timer here: load follows the bit while the host holds it
  assign port1_discharge_load_o = lim1_ff[DSCH_BIT]
                                  && !auto_discharge_enable_i;
  assign port2_discharge_load_o = lim2_ff[DSCH_BIT]
                                  && !auto_discharge_enable_i;
  assign port1_load_parallel_o  = port1_discharge_load_o
                                  && sw_sync_ff[0];
  assign port2_load_parallel_o  = port2_discharge_load_o
                                  && sw_sync_ff[1];

  // ---------------------------------------------------------------
  // read path; unmapped addresses read zero
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr_i)
      ADDR_THR2_HI:  nxt_rdata = port2_threshold_value_ff[15:8];
      ADDR_THR2_LO:  nxt_rdata = port2_threshold_value_ff[7:0];
      ADDR_RATION:   nxt_rdata = ration_config_ff;
      ADDR_LIM1:     nxt_rdata = lim1_ff;
      ADDR_LIM2:     nxt_rdata = lim2_ff;
      ADDR_PRODUCT:  nxt_rdata = PRODUCT_VAL;
      ADDR_MAKER:    nxt_rdata = MAKER_VAL;
      ADDR_REVISION: nxt_rdata = REVISION_VAL;
      default:       nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sleep_default_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    sleep_exit_i |=> lim1_ff == LIM_RST && lim2_ff == LIM_RST)
    else $error("limit registers kept through sleep");
  auto_override_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    auto_discharge_enable_i |-> !port1_discharge_load_o
                                && !port2_discharge_load_o)
    else $error("host load bit not ignored");
  id_read_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == ADDR_MAKER |=> reg_rdata_o == MAKER_VAL)
    else $error("maker code wrong");
  id_write_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == ADDR_PRODUCT
    ##[1:4] reg_rd_i && reg_addr_i == ADDR_PRODUCT
    |=> reg_rdata_o == PRODUCT_VAL)
    else $error("product code changed by write");
  parallel_load_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    port1_load_parallel_o == (port1_discharge_load_o
                              && $past(port1_switch_enable_i, 2)))
    else $error("port 1 parallel load wrong");
  par_load2_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    port2_load_parallel_o == (port2_discharge_load_o
                              && $past(port2_switch_enable_i, 2)))
    else $error("port 2 parallel load wrong");
  tick_gap_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    tick_ff |=> !tick_ff [*8])
    else $error("ticks too close");
  cfg_write_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == ADDR_RATION
    |=> p2.enable == $past(reg_wdata_i[P2_EN_BIT]))
    else $error("ration config write lost");
  lim_write_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == ADDR_LIM2 && !sleep_exit_i
    |=> lim2_ff == $past(reg_wdata_i))
    else $error("limit write lost");
  thr_write_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == ADDR_THR2_LO
    |=> port2_threshold_value_ff[7:0] == $past(reg_wdata_i))
    else $error("threshold low byte write lost");
  clear_status_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    ration_config_ff[P2_CLR_BIT]
    |=> !port2_ration_status_o && !port2_switch_block_o)
    else $error("ration clear left status set");
  disable_undo_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    !ration_config_ff[P1_EN_BIT]
    |=> !port1_switch_block_o && !port1_ration_alert_o)
    else $error("disable left response applied");
  alert_source_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    port1_ration_alert_o
    |-> port1_ration_status_o && !ration_config_ff[P1_RSP_LSB + 1])
    else $error("alert without report response");
  sleep_source_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    sleep_request_o
    |-> port1_ration_status_o || port2_ration_status_o)
    else $error("sleep request without status");
  disc_cv:  cover property (@(posedge ref_clk_i) port2_switch_block_o);
  sleep_cv: cover property (@(posedge ref_clk_i) sleep_request_o);
  load_cv:  cover property (@(posedge ref_clk_i) port1_load_parallel_o);
  clr_cv:   cover property (@(posedge ref_clk_i) ration_config_ff[P2_CLR_BIT]);
endmodule

// >>> verification/smbus_host_model.sv
/*
  smbus host model: byte writes, reads and read-modify-writes on the
  register port of the ration and limit bank.
  assumes the bank samples its strobes on the rising edge of ref_clk_i.
*/
`timescale 1ns/100ps
module smbus_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o
);
  // ---------------------------------------------------------------
  // idle bus
  // ---------------------------------------------------------------
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end
  // ---------------------------------------------------------------
  // transfers
  // ---------------------------------------------------------------
  // released lines show the inverse, so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge ref_clk_i);
    #1 d = reg_rdata_i;
  endtask
  // upper six bits replaced, reserved pair written back as read
  task automatic rmw(input logic [7:0] a, input logic [5:0] hi);
    logic [7:0] d;
    rd(a, d);
    wr(a, {hi, d[1:0]});
  endtask
endmodule

// >>> verification/tb_top.sv
/*
  self-checking bench for the ration and limit register bank.
  assumes ration_pkg is compiled first; the one second tick is never
  reached, so threshold crossings are left to the design's assertions.
*/
`timescale 1ns/100ps
module tb_top;
  import ration_pkg::*;
  logic        ref_clk_i, rst_n_i, reg_wr, reg_rd, active, sleep_exit;
  logic        auto_dis, sw1, sw2, st1, st2, al1, al2, bl1, bl2, slp;
  logic        ld1, ld2, par1, par2;
  logic [7:0]  reg_addr, reg_wdata, rdata;
  logic [15:0] thr1, inc1, inc2;
  logic [1:0]  vs1, vs2;
  logic [2:0]  is1, is2;
  int          mismatches, n_tests;
  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  smbus_host_model host (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd));
  ration_limit_regs dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .port1_threshold_i(thr1),
    .port1_charge_inc_i(inc1), .port2_charge_inc_i(inc2),
    .active_i(active), .sleep_exit_i(sleep_exit),
    .auto_discharge_enable_i(auto_dis), .port1_switch_enable_i(sw1),
    .port2_switch_enable_i(sw2), .port1_ration_status_o(st1),
    .port2_ration_status_o(st2), .port1_ration_alert_o(al1),
    .port2_ration_alert_o(al2), .port1_switch_block_o(bl1),
    .port2_switch_block_o(bl2), .sleep_request_o(slp),
    .port1_discharge_load_o(ld1), .port2_discharge_load_o(ld2),
    .port1_load_parallel_o(par1), .port2_load_parallel_o(par2),
    .port1_min_bus_voltage_sel_o(vs1), .port2_min_bus_voltage_sel_o(vs2),
    .port1_min_current_sel_o(is1), .port2_min_current_sel_o(is2));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic conclude();
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    host.rd(ADDR_RATION, d); chk(16'(d), 16'(RATION_RST));
    host.rd(ADDR_LIM2, d); chk(16'(d), 16'(LIM_RST));
    host.rd(ADDR_THR2_HI, d); chk(16'(d), 16'(THR_RST[15:8]));
    chk(16'(vs1), 16'(LIM_RST[7:6]));
    chk(16'(is2), 16'(LIM_RST[4:2]));
    chk({14'h0000, st1, st2}, 16'h0000);
  endtask
  task automatic t_ids();
    logic [7:0] d;
    logic [7:0] exp [3];
    exp = '{PRODUCT_VAL, MAKER_VAL, REVISION_VAL};
    for (int k = 0; k < 3; k++) begin
      host.wr(8'(ADDR_PRODUCT + k), ~exp[k]);
      host.rd(8'(ADDR_PRODUCT + k), d); chk(16'(d), 16'(exp[k]));
    end
    host.wr(8'h30, 8'h5a);
    host.rd(8'h30, d); chk(16'(d), 16'h0000);
  endtask
  task automatic t_ration();
    logic [7:0] d;
    logic [7:0] v;
    for (int r = 0; r < 4; r++) begin
      v = {2'b10, 2'(r), 2'b10, 2'(3 - r)};
      host.wr(ADDR_RATION, v);
      host.rd(ADDR_RATION, d); chk(16'(d), 16'(v));
    end
    host.wr(ADDR_RATION, 8'hcc);
    settle(); chk({12'h000, st1, st2, al1, al2}, 16'h0000);
    host.wr(ADDR_RATION, 8'h88);
    host.wr(ADDR_RATION, 8'h00);
    settle(); chk({12'h000, bl1, bl2, slp, st2}, 16'h0000);
    host.wr(ADDR_THR2_HI, 8'h12);
    host.wr(ADDR_THR2_LO, 8'h34);
    host.rd(ADDR_THR2_LO, d); chk(16'(d), 16'h0034);
    host.rd(ADDR_THR2_HI, d); chk(16'(d), 16'h0012);
  endtask
  task automatic t_limit();
    logic [7:0] d;
    for (int v = 0; v < 4; v++) begin
      for (int i = 0; i < 6; i++) begin
        host.rmw(ADDR_LIM1, {2'(v), 1'b0, 3'(i)});
        host.rmw(ADDR_LIM2, {2'(3 - v), 1'b0, 3'(5 - i)});
        settle(); chk(16'(vs1), 16'(v));
        chk(16'(vs2), 16'(3 - v));
        chk(16'(is1), 16'(i));
        chk(16'(is2), 16'(5 - i));
      end
    end
    host.rd(ADDR_LIM1, d);
    chk(16'(d), {8'h00, 6'h35, LIM_RST[1:0]});
  endtask
  task automatic t_discharge();
    host.rmw(ADDR_LIM1, 6'h08);
    host.rmw(ADDR_LIM2, 6'h08);
    settle(); chk({12'h000, ld1, par1, ld2, par2}, 16'h000e);
    // pin passes two flops before the parallel path sees it
    sw2 <= 1'b1;
    repeat (2) settle();
    chk({12'h000, ld1, par1, ld2, par2}, 16'h000f);
    auto_dis <= 1'b1;
    settle(); chk({12'h000, ld1, par1, ld2, par2}, 16'h0000);
    auto_dis <= 1'b0;
    settle(); chk({14'h0000, ld1, ld2}, 16'h0003);
    // host's own discharge timer, the bank runs none
    repeat (40) settle();
    chk({14'h0000, ld1, ld2}, 16'h0003);
    host.rmw(ADDR_LIM1, 6'h00);
    settle(); chk({14'h0000, ld1, ld2}, 16'h0001);
  endtask
  task automatic t_sleep();
    logic [7:0] d;
    host.rmw(ADDR_LIM1, 6'h1a);
    host.rd(ADDR_LIM1, d);
    chk(16'(d), {8'h00, 6'h1a, LIM_RST[1:0]});
    @(posedge ref_clk_i);
    sleep_exit <= 1'b1;
    @(posedge ref_clk_i);
    sleep_exit <= 1'b0;
    host.rd(ADDR_LIM1, d); chk(16'(d), 16'(LIM_RST));
    host.rd(ADDR_LIM2, d); chk(16'(d), 16'(LIM_RST));
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    mismatches = 0;
    n_tests    = 0;
    rst_n_i    = 1'b0;
    active     = 1'b1;
    sleep_exit = 1'b0;
    auto_dis   = 1'b0;
    sw1        = 1'b1;
    sw2        = 1'b0;
    thr1       = 16'hffff;
    inc1       = 16'h0001;
    inc2       = 16'h0002;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_ids();
    t_ration();
    t_limit();
    t_discharge();
    t_sleep();
    conclude();
  end
  // whole run needs about 420 cycles
  initial begin
    #(8 * 20000);
    mismatches++;
    conclude();
  end
endmodule
